// file: inc/agu_consts.vh
// constants for the data address generation unit
`ifndef AGU_CONSTS_VH
`define AGU_CONSTS_VH

// ****************************************
// sizes
// ****************************************
`define AGU_SLOTS 3
`define AGU_AW 32
`define AGU_NREG 15
`define AGU_SELW 4
`define AGU_MODEW 4
`define AGU_REG_RESET 32'h00000000
`define AGU_NO_REG 4'hf

// ****************************************
// addressing modes
// ****************************************
`define AGU_M_DIRECT 4'h0
`define AGU_M_OFS28 4'h1
`define AGU_M_OFS10 4'h2
`define AGU_M_OFS10_S2 4'h3
`define AGU_M_OFS8_S2 4'h4
`define AGU_M_REG_IDX 4'h5
`define AGU_M_PRE_INC_IMM 4'h6
`define AGU_M_PRE_DEC_IMM 4'h7
`define AGU_M_POST_INC_IMM 4'h8
`define AGU_M_POST_DEC_IMM 4'h9
`define AGU_M_PRE_INC_REG 4'ha
`define AGU_M_PRE_DEC_REG 4'hb
`define AGU_M_POST_INC_REG 4'hc
`define AGU_M_POST_DEC_REG 4'hd
`define AGU_M_OFS7_INC_REG 4'he

// ****************************************
// access widths
// ****************************************
`define AGU_W_BYTE 2'h0
`define AGU_W_HALF 2'h1
`define AGU_W_WORD 2'h2
`define AGU_W_DWORD 2'h3

// ****************************************
// immediate field positions
// ****************************************
`define AGU_IMM28_MSB 27
`define AGU_IMM10_MSB 9
`define AGU_IMM8_MSB 7
`define AGU_IMM7_MSB 6
`define AGU_SHIFT_MSB 1

`endif

// file: design/agu_width_dec.v
// access width decoder: step, scale and alignment mask
`timescale 1ns/1ps
`include "agu_consts.vh"

module agu_width_dec (
   input wire [1:0] width_in, // access width code
   output reg [3:0] step_out, // bytes per access
   output reg [1:0] scale_out, // index shift
   output reg [2:0] mask_out // low address bits that must be zero
);

   // ****************************************
   // width decode
   // ****************************************

   // byte, 16, 32 and 64 bit steps, scales and masks
   always @*
   begin
      case (width_in)
         `AGU_W_BYTE:
         begin
            step_out = 4'h1;
            scale_out = 2'h0;
            mask_out = 3'h0;
         end
         `AGU_W_HALF:
         begin
            step_out = 4'h2;
            scale_out = 2'h1;
            mask_out = 3'h1;
         end
         `AGU_W_WORD:
         begin
            step_out = 4'h4;
            scale_out = 2'h2;
            mask_out = 3'h3;
         end
         default:
         begin
            step_out = 4'h8;
            scale_out = 2'h3;
            mask_out = 3'h7;
         end
      endcase
   end

endmodule

// file: design/agu_ptr_regs.v
// address pointer register file with packet and load write ports
`timescale 1ns/1ps
`include "agu_consts.vh"

module agu_ptr_regs (
   input wire clk_in, // core clock
   input wire reset_in, // sync reset, active high
   input wire [2:0] wr_en_in, // per slot pointer update
   input wire [11:0] wr_sel_in, // per slot register number
   input wire [95:0] wr_data_in, // per slot updated value
   input wire load_valid_in, // plain pointer load
   input wire [3:0] load_sel_in, // register to load
   input wire [31:0] load_data_in, // value to load
   output wire [479:0] all_regs_out // every pointer, reg 0 lowest
);

   reg [31:0] ptr [0:14];
   integer i;
   integer s;

   // ****************************************
   // storage
   // ****************************************

   // slot updates are unique per register, so they override a load
   always @(posedge clk_in)
   begin
      for (i = 0; i < `AGU_NREG; i = i + 1)
      begin
         if (reset_in)
            ptr[i] <= `AGU_REG_RESET;
         else
         begin
            if (load_valid_in && load_sel_in == i[3:0])
               ptr[i] <= load_data_in;
            for (s = 0; s < `AGU_SLOTS; s = s + 1)
               if (wr_en_in[s] && wr_sel_in[4*s +: 4] == i[3:0])
                  ptr[i] <= wr_data_in[32*s +: 32];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < `AGU_NREG; g = g + 1)
      begin : flat
         assign all_regs_out[32*g +: 32] = ptr[g];
      end
   endgenerate

endmodule

// file: design/agu_top.v
// data address generation for two loads and one store per packet
`timescale 1ns/1ps
`include "agu_consts.vh"

// Functional notes
// [RULE1] direct 32-bit address, 48-bit instructions only
// [RULE2] pointer 0..14 plus immediate, wrapping add
// [RULE3] unshifted 28-bit unsigned offset
// [RULE4] unshifted 10-bit unsigned offset
// [RULE5] 10-bit offset shifted left by two
// [RULE6] 8-bit offset <<2, move instruction only
// [RULE7] base plus optionally shifted index register
// [RULE8] index shift matches access width
// [RULE9] index add wraps, all ones is minus one
// [RULE10] immediate pre or post pointer update
// [RULE11] immediate increment wraps at 32 bits
// [RULE12] immediate decrement wraps at 32 bits
// [RULE13] implicit field derives step, scale from width
// [RULE14] pointer update by another pointer register
// [RULE15] 7-bit offset access, then add pointer
// [RULE16] software keeps addresses width aligned
// [RULE17] misaligned address raises addressing fault
// [RULE18] three accesses, one write per register
// [RULE19] pre uses new value, post uses old
module agu_top (
   input wire clk_in, // core clock, 100 MHz
   input wire reset_in, // sync reset, active high
   input wire [2:0] slot_valid_in, // slots 0,1 load, 2 store
   input wire [11:0] slot_mode_in, // addressing mode per slot
   input wire [5:0] slot_width_in, // access width per slot
   input wire [2:0] implicit_scale_opcode_field_in, // width sets step
   input wire [11:0] base_pointer_reg_in, // base register number
   input wire [11:0] step_pointer_reg_in, // index or step register
   input wire [95:0] slot_imm_in, // instruction immediate per slot
   input wire [2:0] slot_long_instr_in, // 48-bit encoding
   input wire [2:0] slot_move_instr_in, // array move instruction
   input wire ptr_load_valid_in, // plain pointer load
   input wire [3:0] ptr_load_sel_in, // pointer to load
   input wire [31:0] ptr_load_data_in, // value to load
   input wire [3:0] ptr_peek_sel_in, // pointer to read back
   output reg [31:0] ptr_peek_data_out, // read back value
   output reg [2:0] acc_valid_out, // access issued
   output reg [95:0] acc_addr_out, // access byte address
   output reg [5:0] acc_width_out, // width of issued access
   output reg [2:0] align_fault_out, // misaligned address pulse
   output reg [2:0] mode_fault_out, // illegal mode pulse
   output reg [2:0] write_clash_out // pointer update dropped pulse
);

   // ****************************************
   // helpers
   // ****************************************

   // true for the one number that names no pointer register
   function no_pointer;
      input [3:0] sel;
      begin
         no_pointer = (sel == `AGU_NO_REG);
      end
   endfunction

   // pointer read mux, register 15 is not a pointer here
   function [31:0] pick_reg;
      input [479:0] regs;
      input [3:0] sel;
      begin
         if (no_pointer(sel))
            pick_reg = `AGU_REG_RESET;
         else
            pick_reg = regs[32*sel +: 32];
      end
   endfunction

   // two slots want to write the same pointer
   function same_write;
      input want_a;
      input want_b;
      input [3:0] sel_a;
      input [3:0] sel_b;
      begin
         same_write = want_a && want_b && (sel_a == sel_b);
      end
   endfunction

   wire [479:0] all_regs;
   wire [95:0] calc_addr;
   wire [95:0] calc_upd;
   wire [2:0] calc_wr;
   wire [2:0] calc_misalign;
   wire [2:0] calc_bad;
   wire [2:0] want_wr;
   wire [2:0] clash;
   wire [2:0] commit_wr;

   // ****************************************
   // per slot address arithmetic
   // ****************************************

   // slots share the pointer file but never see each other's updates
   genvar g;
   generate
      for (g = 0; g < `AGU_SLOTS; g = g + 1)
      begin : slot
         wire [3:0] mode = slot_mode_in[4*g +: 4];
         wire [1:0] width = slot_width_in[2*g +: 2];
         wire [31:0] imm = slot_imm_in[32*g +: 32];
         wire [3:0] bsel = base_pointer_reg_in[4*g +: 4];
         wire [3:0] ssel = step_pointer_reg_in[4*g +: 4];
         wire [31:0] base = pick_reg(all_regs, bsel);
         wire [31:0] other = pick_reg(all_regs, ssel);
         wire [3:0] wstep;
         wire [1:0] wscale;
         wire [2:0] wmask;
         reg [31:0] step_imm;
         reg [1:0] shift;
         reg [31:0] addr;
         reg [31:0] upd;
         reg wr;
         reg bad;

         agu_width_dec u_dec (
            .width_in(width),
            .step_out(wstep),
            .scale_out(wscale),
            .mask_out(wmask)
         );

         // implicit field replaces step and shift by width values
         always @*
         begin
            if (implicit_scale_opcode_field_in[g])
            begin
               step_imm = {28'h0000000, wstep}; // [RULE13]
               shift = wscale; // [RULE13] [RULE8]
            end
            else
            begin
               step_imm = imm;
               shift = imm[`AGU_SHIFT_MSB:0];
            end
         end

         // all sums are 32 bits wide and drop the carry on purpose
         always @*
         begin
            addr = base;
            upd = base;
            wr = 1'b0;
            bad = no_pointer(bsel); // [RULE2]
            case (mode)
               `AGU_M_DIRECT:
               begin
                  addr = imm;
                  bad = !slot_long_instr_in[g]; // [RULE1]
               end
               `AGU_M_OFS28:
                  addr = base + {4'h0, imm[`AGU_IMM28_MSB:0]}; // [RULE3]
               `AGU_M_OFS10:
                  addr = base + {22'h0, imm[`AGU_IMM10_MSB:0]}; // [RULE4]
               `AGU_M_OFS10_S2:
                  addr = base + {20'h0, imm[`AGU_IMM10_MSB:0], 2'h0}; // [RULE5]
               `AGU_M_OFS8_S2:
               begin
                  addr = base + {22'h0, imm[`AGU_IMM8_MSB:0], 2'h0}; // [RULE6]
                  bad = bad || !slot_move_instr_in[g]; // [RULE6]
               end
               `AGU_M_REG_IDX:
               begin
                  addr = base + (other << shift); // [RULE7] [RULE9]
                  bad = bad || (ssel == `AGU_NO_REG);
               end
               `AGU_M_PRE_INC_IMM:
               begin
                  upd = base + step_imm; // [RULE11]
                  addr = upd; // [RULE19]
                  wr = 1'b1; // [RULE10]
               end
               `AGU_M_PRE_DEC_IMM:
               begin
                  upd = base - step_imm; // [RULE12]
                  addr = upd; // [RULE19]
                  wr = 1'b1; // [RULE10]
               end
               `AGU_M_POST_INC_IMM:
               begin
                  upd = base + step_imm; // [RULE11]
                  wr = 1'b1; // [RULE10] [RULE19]
               end
               `AGU_M_POST_DEC_IMM:
               begin
                  upd = base - step_imm; // [RULE12]
                  wr = 1'b1; // [RULE10] [RULE19]
               end
               `AGU_M_PRE_INC_REG:
               begin
                  upd = base + other; // [RULE14]
                  addr = upd; // [RULE19]
                  wr = 1'b1;
                  bad = bad || (ssel == `AGU_NO_REG);
               end
               `AGU_M_PRE_DEC_REG:
               begin
                  upd = base - other; // [RULE14]
                  addr = upd; // [RULE19]
                  wr = 1'b1;
                  bad = bad || (ssel == `AGU_NO_REG);
               end
               `AGU_M_POST_INC_REG:
               begin
                  upd = base + other; // [RULE14] [RULE19]
                  wr = 1'b1;
                  bad = bad || (ssel == `AGU_NO_REG);
               end
               `AGU_M_POST_DEC_REG:
               begin
                  upd = base - other; // [RULE14] [RULE19]
                  wr = 1'b1;
                  bad = bad || (ssel == `AGU_NO_REG);
               end
               `AGU_M_OFS7_INC_REG:
               begin
                  addr = base + {25'h0, imm[`AGU_IMM7_MSB:0]}; // [RULE15]
                  upd = base + other; // [RULE15]
                  wr = 1'b1;
                  bad = bad || (ssel == `AGU_NO_REG);
               end
               default:
                  bad = 1'b1;
            endcase
         end

         assign calc_addr[32*g +: 32] = addr;
         assign calc_upd[32*g +: 32] = upd;
         assign calc_wr[g] = wr;
         assign calc_bad[g] = bad;
         // memory enforces alignment, so flag it here [RULE17]
         assign calc_misalign[g] = |(addr[2:0] & wmask);
         // a faulted access leaves its pointer untouched
         assign want_wr[g] = slot_valid_in[g] && wr && !bad &&
                             !calc_misalign[g];
      end
   endgenerate

   // ****************************************
   // one write per pointer per packet
   // ****************************************

   // lower slot keeps the write; a later duplicate is dropped [RULE18]
   assign clash[0] = 1'b0;
   assign clash[1] = same_write(want_wr[0], want_wr[1],
                                base_pointer_reg_in[3:0],
                                base_pointer_reg_in[7:4]);
   assign clash[2] = same_write(want_wr[0], want_wr[2],
                                base_pointer_reg_in[3:0],
                                base_pointer_reg_in[11:8]) ||
                     same_write(want_wr[1], want_wr[2],
                                base_pointer_reg_in[7:4],
                                base_pointer_reg_in[11:8]);
   assign commit_wr = want_wr & ~clash; // [RULE18]

   // all slots read the values from before this packet
   agu_ptr_regs u_regs (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .wr_en_in(commit_wr),
      .wr_sel_in(base_pointer_reg_in),
      .wr_data_in(calc_upd),
      .load_valid_in(ptr_load_valid_in),
      .load_sel_in(ptr_load_sel_in),
      .load_data_in(ptr_load_data_in),
      .all_regs_out(all_regs)
   );

   // ****************************************
   // registered access outputs
   // ****************************************

   // one cycle from packet to bus request, faults are single pulses
   always @(posedge clk_in)
   begin
      if (reset_in)
      begin
         acc_valid_out <= 3'h0;
         acc_addr_out <= 96'h0;
         acc_width_out <= 6'h0;
         align_fault_out <= 3'h0;
         mode_fault_out <= 3'h0;
         write_clash_out <= 3'h0;
         ptr_peek_data_out <= `AGU_REG_RESET;
      end
      else
      begin
         acc_valid_out <= slot_valid_in & ~calc_bad & ~calc_misalign;
         acc_addr_out <= calc_addr;
         acc_width_out <= slot_width_in;
         // post modes judge the old pointer, the address that goes out
         align_fault_out <= slot_valid_in & ~calc_bad &
                            calc_misalign; // [RULE17]
         mode_fault_out <= slot_valid_in & calc_bad;
         write_clash_out <= clash; // [RULE18]
         ptr_peek_data_out <= pick_reg(all_regs, ptr_peek_sel_in);
      end
   end

endmodule

// file: bench/agu_top_asserts.sv
// port checker for the data address generation unit
`timescale 1ns/1ps
`include "agu_consts.vh"

module agu_top_asserts (
   input wire clk_in, // core clock
   input wire reset_in, // sync reset
   input wire [2:0] slot_valid_in, // requests
   input wire [11:0] slot_mode_in, // modes
   input wire [5:0] slot_width_in, // widths
   input wire [2:0] implicit_scale_opcode_field_in, // implicit
   input wire [11:0] base_pointer_reg_in, // bases
   input wire [11:0] step_pointer_reg_in, // steps
   input wire [95:0] slot_imm_in, // immediates
   input wire [2:0] slot_long_instr_in, // long encoding
   input wire [2:0] slot_move_instr_in, // move instr
   input wire ptr_load_valid_in, // load strobe
   input wire [3:0] ptr_load_sel_in, // load pointer
   input wire [31:0] ptr_load_data_in, // load value
   input wire [3:0] ptr_peek_sel_in, // peek pointer
   input wire [31:0] ptr_peek_data_out, // peek value
   input wire [2:0] acc_valid_out, // issued
   input wire [95:0] acc_addr_out, // addresses
   input wire [5:0] acc_width_out, // widths
   input wire [2:0] align_fault_out, // align faults
   input wire [2:0] mode_fault_out, // mode faults
   input wire [2:0] write_clash_out // dropped updates
);
   // ****************************************
   // slot 0 relations, and the slot 1 clash
   // ****************************************
   wire v0 = slot_valid_in[0];
   wire [3:0] m0 = slot_mode_in[3:0];
   // mask of low bits that must be clear for the issued width
   wire [3:0] msk = (4'h1 << acc_width_out[1:0]) - 4'h1;
   wire al0 = (acc_addr_out[2:0] & msk[2:0]) == 3'h0;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   AST_QUIET: assert property (!v0 |=> !(acc_valid_out[0] |
      align_fault_out[0] | mode_fault_out[0])) else $error("stray answer");
   AST_ONE: assert property (v0 |=> $onehot({acc_valid_out[0],
      align_fault_out[0], mode_fault_out[0]})) else $error("no answer");
   AST_DIRECT: assert property (v0 && m0 == `AGU_M_DIRECT
      && slot_long_instr_in[0] |=> acc_addr_out[31:0] ==
      $past(slot_imm_in[31:0])) else $error("direct address wrong");
   AST_SHORT: assert property (v0 && m0 == `AGU_M_DIRECT
      && !slot_long_instr_in[0] |=> mode_fault_out[0])
      else $error("short direct taken");
   AST_MOVE: assert property (v0 && m0 == `AGU_M_OFS8_S2
      && !slot_move_instr_in[0] |=> mode_fault_out[0])
      else $error("short offset outside move");
   AST_BASE: assert property (v0 && m0 == `AGU_M_OFS28
      && base_pointer_reg_in[3:0] == 4'hf |=> mode_fault_out[0])
      else $error("pointer 15 taken");
   AST_ALIGN: assert property (acc_valid_out[0] |-> al0)
      else $error("misaligned access issued");
   AST_MISAL: assert property (align_fault_out[0] |-> !al0)
      else $error("aligned access faulted");
   AST_WIDTH: assert property (acc_valid_out[0] |->
      acc_width_out[1:0] == $past(slot_width_in[1:0]))
      else $error("width not copied");
   AST_NOCLASH: assert property (!write_clash_out[0])
      else $error("top slot update dropped");
   AST_CLASHISS: assert property (write_clash_out[1] |->
      acc_valid_out[1] && acc_valid_out[0])
      else $error("clash without both accesses");
   COV_DIRECT: cover property (v0 && m0 == `AGU_M_DIRECT ##1 acc_valid_out[0]);
   COV_ALIGN: cover property (align_fault_out[0]);
   COV_CLASH: cover property (write_clash_out[1]);
endmodule

// file: bench/agu_mem_model.sv
// data memory model that takes the issued accesses
`timescale 1ns/1ps

module agu_mem_model (
   input wire clk_in, // core clock
   input wire [2:0] acc_valid_in, // access strobes
   input wire [95:0] acc_addr_in, // addresses
   input wire [5:0] acc_width_in, // widths
   output reg bad_out = 1'b0 // misaligned access seen
);
   integer g;
   // memory enforces alignment itself, so a stray access is latched
   always @(posedge clk_in)
   begin
      for (g = 0; g < 3; g = g + 1)
      begin
         if (acc_valid_in[g] && |(acc_addr_in[32*g +: 3] &
             ~(3'h7 << acc_width_in[2*g +: 2])))
            bad_out <= 1'b1;
      end
   end
endmodule

// file: bench/tb.sv
// self-checking testbench for the address generation unit
`timescale 1ns/1ps
`include "agu_consts.vh"

module tb;
   reg clk_in = 1'b0;
   reg reset_in = 1'b1;
   reg [2:0] valid = 3'h0, lng = 3'h0, mov = 3'h0, imp = 3'h0;
   reg [11:0] mode = 12'h0, base = 12'h0, step = 12'h0;
   reg [5:0] width = 6'h0;
   reg [95:0] imm = 96'h0;
   reg ld_v = 1'b0;
   reg [3:0] ld_sel = 4'h0, pk_sel = 4'h0;
   reg [31:0] ld_dat = 32'h0;
   wire [31:0] pk;
   wire [2:0] av, af, mf, wc;
   wire [95:0] aa;
   wire [5:0] aw;
   wire bad;
   integer n_errors = 0;
   integer n_checks = 0;
   always #5 clk_in = ~clk_in;

   agu_top u_agu_top (.clk_in(clk_in), .reset_in(reset_in),
      .slot_valid_in(valid), .slot_mode_in(mode), .slot_width_in(width),
      .implicit_scale_opcode_field_in(imp), .base_pointer_reg_in(base),
      .step_pointer_reg_in(step), .slot_imm_in(imm),
      .slot_long_instr_in(lng), .slot_move_instr_in(mov),
      .ptr_load_valid_in(ld_v), .ptr_load_sel_in(ld_sel),
      .ptr_load_data_in(ld_dat), .ptr_peek_sel_in(pk_sel),
      .ptr_peek_data_out(pk), .acc_valid_out(av), .acc_addr_out(aa),
      .acc_width_out(aw), .align_fault_out(af), .mode_fault_out(mf),
      .write_clash_out(wc));
   agu_mem_model u_agu_mem_model (.clk_in(clk_in), .acc_valid_in(av),
      .acc_addr_in(aa), .acc_width_in(aw), .bad_out(bad));

   // ****************************************
   // shared tasks
   // ****************************************
   task chk(input [31:0] got, input [31:0] exp);
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // f is {implicit, move, long}
   task slot(input integer g, input [3:0] m, input [1:0] w, input [3:0] b,
             input [3:0] s, input [31:0] i, input [2:0] f);
      mode[4*g +: 4] = m;
      width[2*g +: 2] = w;
      base[4*g +: 4] = b;
      step[4*g +: 4] = s;
      imm[32*g +: 32] = i;
      {imp[g], mov[g], lng[g]} = f;
   endtask
   // one packet; returns with its answer settled
   task fire(input [2:0] v);
      @(posedge clk_in);
      #1 valid = v;
      @(posedge clk_in);
      #1 valid = 3'h0;
   endtask
   task one(input [3:0] m, input [1:0] w, input [3:0] b, input [3:0] s,
            input [31:0] i, input [2:0] f);
      slot(0, m, w, b, s, i, f);
      fire(3'h1);
   endtask
   // o is {mode fault, align fault, issued}
   task res(input [2:0] o, input [31:0] a);
      chk({29'h0, mf[0], af[0], av[0]}, {29'h0, o});
      if (o == 3'h1)
         chk(aa[31:0], a);
   endtask
   task load(input [3:0] r, input [31:0] d);
      @(posedge clk_in);
      #1 ld_v = 1'b1;
      ld_sel = r;
      ld_dat = d;
      @(posedge clk_in);
      #1 ld_v = 1'b0;
   endtask
   task peek(input [3:0] r, input [31:0] e);
      pk_sel = r;
      @(posedge clk_in);
      #1 chk(pk, e);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task t_direct;
      one(`AGU_M_DIRECT, `AGU_W_WORD, 0, 0, 32'h12345670, 3'h1);
      res(3'h1, 32'h12345670);
      one(`AGU_M_DIRECT, `AGU_W_WORD, 0, 0, 32'h12345670, 3'h0);
      res(3'h4, 32'h0);
      one(4'hf, `AGU_W_WORD, 0, 0, 32'h0, 3'h1);
      res(3'h4, 32'h0);
      $display("done direct");
   endtask
   task t_offset;
      load(2, 32'hfffffff0);
      one(`AGU_M_OFS28, `AGU_W_WORD, 2, 0, 32'hf0000020, 3'h0);
      res(3'h1, 32'h10);
      one(`AGU_M_OFS10, `AGU_W_BYTE, 2, 0, 32'hc05, 3'h0);
      res(3'h1, 32'hfffffff5);
      one(`AGU_M_OFS10_S2, `AGU_W_WORD, 2, 0, 32'h7ff, 3'h0);
      res(3'h1, 32'hfec);
      one(`AGU_M_OFS8_S2, `AGU_W_WORD, 2, 0, 32'h1ff, 3'h2);
      res(3'h1, 32'h3ec);
      one(`AGU_M_OFS8_S2, `AGU_W_WORD, 2, 0, 32'h1ff, 3'h0);
      res(3'h4, 32'h0);
      one(`AGU_M_OFS28, `AGU_W_WORD, 4'hf, 0, 32'h0, 3'h0);
      res(3'h4, 32'h0);
      $display("done offset");
   endtask
   task t_index;
      load(3, 32'h100);
      load(4, 32'h7);
      one(`AGU_M_REG_IDX, `AGU_W_WORD, 3, 4, 32'h2, 3'h0);
      res(3'h1, 32'h11c);
      one(`AGU_M_REG_IDX, `AGU_W_HALF, 3, 4, 32'h1, 3'h0);
      res(3'h1, 32'h10e);
      one(`AGU_M_REG_IDX, `AGU_W_DWORD, 3, 4, 32'h0, 3'h4);
      res(3'h1, 32'h138);
      load(4, 32'hffffffff);
      one(`AGU_M_REG_IDX, `AGU_W_BYTE, 3, 4, 32'h0, 3'h0);
      res(3'h1, 32'hff);
      $display("done index");
   endtask
   task t_imm_step;
      load(5, 32'h10);
      one(`AGU_M_POST_INC_IMM, `AGU_W_WORD, 5, 0, 32'h4, 3'h0);
      res(3'h1, 32'h10);
      peek(5, 32'h14);
      one(`AGU_M_PRE_DEC_IMM, `AGU_W_WORD, 5, 0, 32'h8, 3'h0);
      res(3'h1, 32'hc);
      load(5, 32'hfffffff8);
      one(`AGU_M_PRE_INC_IMM, `AGU_W_DWORD, 5, 0, 32'h0, 3'h4);
      res(3'h1, 32'h0);
      one(`AGU_M_POST_DEC_IMM, `AGU_W_HALF, 5, 0, 32'h2, 3'h0);
      res(3'h1, 32'h0);
      peek(5, 32'hfffffffe);
      $display("done immediate step");
   endtask
   task t_reg_step;
      load(6, 32'h20);
      load(7, 32'h8);
      one(`AGU_M_PRE_INC_REG, `AGU_W_WORD, 6, 7, 32'h0, 3'h0);
      res(3'h1, 32'h28);
      one(`AGU_M_POST_DEC_REG, `AGU_W_WORD, 6, 7, 32'h0, 3'h0);
      res(3'h1, 32'h28);
      one(`AGU_M_PRE_DEC_REG, `AGU_W_WORD, 6, 7, 32'h0, 3'h0);
      res(3'h1, 32'h18);
      one(`AGU_M_POST_INC_REG, `AGU_W_WORD, 6, 7, 32'h0, 3'h0);
      res(3'h1, 32'h18);
      one(`AGU_M_OFS7_INC_REG, `AGU_W_WORD, 6, 7, 32'h84, 3'h0);
      res(3'h1, 32'h24);
      peek(6, 32'h28);
      $display("done register step");
   endtask
   task t_align;
      load(8, 32'h6);
      one(`AGU_M_OFS28, `AGU_W_WORD, 8, 0, 32'h0, 3'h0);
      res(3'h2, 32'h0);
      one(`AGU_M_POST_INC_IMM, `AGU_W_WORD, 8, 0, 32'h4, 3'h0);
      res(3'h2, 32'h0);
      peek(8, 32'h6);
      one(`AGU_M_OFS28, `AGU_W_HALF, 8, 0, 32'h0, 3'h0);
      res(3'h1, 32'h6);
      $display("done alignment");
   endtask
   task t_packet;
      load(9, 32'h40);
      load(10, 32'h4);
      slot(0, `AGU_M_POST_INC_IMM, `AGU_W_WORD, 9, 0, 32'h8, 3'h0);
      slot(1, `AGU_M_POST_INC_REG, `AGU_W_WORD, 9, 10, 32'h0, 3'h0);
      slot(2, `AGU_M_REG_IDX, `AGU_W_WORD, 9, 10, 32'h0, 3'h4);
      fire(3'h7);
      chk({29'h0, av}, 32'h7);
      chk({29'h0, wc}, 32'h2);
      chk(aa[63:32], 32'h40);
      chk(aa[95:64], 32'h50);
      chk({26'h0, af, mf}, 32'h0);
      chk({26'h0, aw}, 32'h2a);
      peek(9, 32'h48);
      $display("done packet");
   endtask

   task stop_test;
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (12) @(posedge clk_in);
      #1 reset_in = 1'b0;
      chk({20'h0, av, af, mf, wc}, 32'h0);
      peek(2, 32'h0);
      t_direct;
      t_offset;
      t_index;
      t_imm_step;
      t_reg_step;
      t_align;
      t_packet;
      chk({31'h0, bad}, 32'h0);
      stop_test;
   end
   // hang guard
   initial
   begin
      #500000;
      n_errors = n_errors + 1;
      stop_test;
   end
endmodule

bind agu_top agu_top_asserts u_agu_top_asserts (.clk_in(clk_in),
   .reset_in(reset_in), .slot_valid_in(slot_valid_in),
   .slot_mode_in(slot_mode_in), .slot_width_in(slot_width_in),
   .implicit_scale_opcode_field_in(implicit_scale_opcode_field_in),
   .base_pointer_reg_in(base_pointer_reg_in),
   .step_pointer_reg_in(step_pointer_reg_in), .slot_imm_in(slot_imm_in),
   .slot_long_instr_in(slot_long_instr_in),
   .slot_move_instr_in(slot_move_instr_in),
   .ptr_load_valid_in(ptr_load_valid_in), .ptr_load_sel_in(ptr_load_sel_in),
   .ptr_load_data_in(ptr_load_data_in), .ptr_peek_sel_in(ptr_peek_sel_in),
   .ptr_peek_data_out(ptr_peek_data_out), .acc_valid_out(acc_valid_out),
   .acc_addr_out(acc_addr_out), .acc_width_out(acc_width_out),
   .align_fault_out(align_fault_out), .mode_fault_out(mode_fault_out),
   .write_clash_out(write_clash_out));
